/* File: crrl_pkg.sv */
// ***********************************************************
// shared constants
// ***********************************************************
package crrl_pkg;
   localparam int NUM_WORDS = 32;
   localparam int NUM_SEL = 14;
   localparam int NUM_ITEMS = 8;
   localparam int NUM_SLOTS = 5;
   localparam int NUM_EXEC = NUM_SLOTS + 1;
   localparam int FIRST_USER_WORD = 4;
   localparam int REPLY_WORD = 2;
   localparam int READ_WORD = 3;
   localparam int SLOT_WORD_BASE = 16;
   // item index numbers; the base value is arbitrary
   localparam logic [15:0] ITEM_INDEX_BASE = 16'h0001;
   localparam logic [15:0] SEL_NONE = 16'h270f;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FREQ_MAX = 8'h04;
   localparam logic [7:0] OFS_TORQUE_MAX = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] OFS_SET_FREQ = 8'h1c;
   localparam logic [7:0] OFS_ITEM_WIDE = 8'h20;
   localparam logic [7:0] OFS_ITEM_BASE = 8'h40;
   localparam logic [7:0] OFS_SEL_BASE = 8'h80;
   // control field positions
   localparam int CTRL_SIGN_BIT = 0;
   localparam int CTRL_TORQUE_BIT = 1;
   localparam int CTRL_SLOT_LAYOUT_BIT = 2;
   localparam int CTRL_MODE_SEL_LSB = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] FREQ_MAX_RESET = 16'hffff;
   localparam logic [15:0] TORQUE_MAX_RESET = 16'hffff;
   // interrupt event bits
   localparam int EV_FREQ_DONE = 0;
   localparam int EV_INSTR_DONE = 1;
   localparam int EV_FAULT = 2;
   localparam int NUM_EV = 3;
   // operation modes and instruction codes
   localparam logic [1:0] MODE_NET = 2'h0;
   localparam logic [1:0] MODE_EXT = 2'h1;
   localparam logic [1:0] MODE_PANEL = 2'h2;
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam logic [7:0] CODE_MODE_READ = 8'h7b;
   localparam logic [7:0] CODE_MODE_WRITE = 8'hfb;
   localparam logic [3:0] MODE_SEL_PANEL_OK = 4'h6;
   localparam int CODE_WRITE_BIT = 7;
   // reply codes
   localparam logic [7:0] RC_OK = 8'h00;
   localparam logic [7:0] RC_MODE_FAULT = 8'h01;
   localparam logic [7:0] RC_BAD_CODE = 8'h02;
   localparam logic [7:0] RC_RANGE = 8'h03;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage : crrl_pkg

// ***********************************************************
// user output item selection
// ***********************************************************
module crrl_item_sel
   import crrl_pkg::*;
(
   input wire logic [15:0] sel_index,
   input wire logic [NUM_ITEMS*32-1:0] item_data,
   input wire logic [NUM_ITEMS-1:0] item_wide,
   output logic [31:0] item_value
);
   logic [15:0] offset;

   always_comb begin
      offset = sel_index - ITEM_INDEX_BASE;
      item_value = 32'h0000_0000;
      // unknown index and the none value both land here as zero
      if (sel_index != SEL_NONE && sel_index >= ITEM_INDEX_BASE &&
          offset < 16'(NUM_ITEMS)) begin
         item_value = item_data[offset[2:0]*32 +: 32];
         if (!item_wide[offset[2:0]]) begin
            item_value[31:16] = 16'h0000;
         end
      end
   end
endmodule : crrl_item_sel

/* File: crrl_reply.sv */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
module crrl_reply
   import crrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic freq_set_request_ram,
   input wire logic freq_set_request_nv,
   input wire logic instr_exec_request,
   input wire logic [15:0] freq_command,
   input wire logic [15:0] torque_command,
   input wire logic [crrl_pkg::NUM_EXEC*8-1:0] instr_code,
   input wire logic [crrl_pkg::NUM_EXEC*16-1:0] instr_data,
   input wire logic drive_stopped,
   output logic [crrl_pkg::NUM_WORDS*16-1:0] response_word_area,
   output logic [1:0] op_mode,
   output logic [15:0] set_freq,
   output logic reverse_dir,
   output logic irq
);
   import crrl_pkg::*;

   // ***********************************************************
   // state
   // ***********************************************************
   logic [31:0] ctrl_reg, ctrl_next;
   logic [15:0] freq_max_reg, freq_max_next;
   logic [15:0] torque_max_reg, torque_max_next;
   logic [NUM_EV-1:0] irq_status_reg, irq_status_next;
   logic [NUM_EV-1:0] irq_enable_reg, irq_enable_next;
   logic [NUM_ITEMS-1:0] item_wide_reg, item_wide_next;
   logic [NUM_ITEMS*32-1:0] item_data_reg, item_data_next;
   logic [NUM_SEL*16-1:0] sel_reg, sel_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [1:0] op_mode_reg, op_mode_next;
   logic [7:0] reply1_reg, reply1_next;
   logic [7:0] reply2_reg, reply2_next;
   logic [15:0] read_data_word_reg, read_data_word_next;
   logic [NUM_SLOTS*16-1:0] slot_reply_reg, slot_reply_next;
   logic [NUM_SLOTS*16-1:0] slot_data_reg, slot_data_next;
   logic [15:0] set_freq_reg, set_freq_next;
   logic reverse_reg, reverse_next;
   logic [NUM_WORDS*16-1:0] resp_reg, resp_next;
   logic [NUM_SEL*32-1:0] user_values;
   logic wr_go, rd_go, freq_go;
   logic [NUM_EV-1:0] ev_set;
   logic [NUM_EV-1:0] ev_clear;

   // parameter writes only pass while stopped in network mode
   function automatic logic write_allowed(input logic [1:0] mode,
                                          input logic stopped);
      write_allowed = (mode == MODE_NET) && stopped;
   endfunction : write_allowed

   // result: {new mode, reply code, read data}
   function automatic logic [33:0] exec_instr(input logic [7:0] code,
      input logic [15:0] data, input logic [1:0] mode,
      input logic stopped, input logic [3:0] mode_sel);
      logic [1:0] m;
      logic [15:0] rc;
      logic [15:0] rd;
      m = mode;
      rc = {8'h00, RC_OK};
      rd = 16'h0000;
      if (code == CODE_MODE_READ) begin
         rd = {14'h0000, mode};
      end else if (code == CODE_MODE_WRITE) begin
         if (!stopped) begin
            rc = {8'h00, RC_MODE_FAULT};
         end else if (data == {14'h0000, MODE_NET} ||
                      data == {14'h0000, MODE_EXT} ||
                      (data == {14'h0000, MODE_PANEL} &&
                       mode_sel == MODE_SEL_PANEL_OK)) begin
            m = data[1:0];
         end else begin
            rc = {8'h00, RC_RANGE};
         end
      end else if (code[CODE_WRITE_BIT] && !write_allowed(mode, stopped)) begin
         rc = {8'h00, RC_MODE_FAULT};
      end else begin
         rc = {8'h00, RC_BAD_CODE};
      end
      exec_instr = {m, rc, rd};
   endfunction : exec_instr

   function automatic logic [7:0] range_reply(input logic [15:0] mag,
      input logic [15:0] limit, input logic ok_mode);
      if (mag > limit) begin
         range_reply = RC_RANGE;
      end else if (!ok_mode) begin
         range_reply = RC_MODE_FAULT;
      end else begin
         range_reply = RC_OK;
      end
   endfunction : range_reply

   // ***********************************************************
   // user output items
   // ***********************************************************
   for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
      crrl_item_sel u_sel (
         .sel_index(sel_reg[g*16 +: 16]),
         .item_data(item_data_reg),
         .item_wide(item_wide_reg),
         .item_value(user_values[g*32 +: 32])
      );
   end

   // ***********************************************************
   // bus slave
   // ***********************************************************
   // write address and data are taken together, one write in flight
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   assign rd_go = s_axi_arvalid && !rvalid_reg;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_comb begin
      logic [7:0] wa;
      logic [7:0] ra;
      logic [31:0] wm;
      logic hit;
      wa = s_axi_awaddr[7:0];
      ra = s_axi_araddr[7:0];
      wm = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      hit = 1'b0;
      ctrl_next = ctrl_reg;
      freq_max_next = freq_max_reg;
      torque_max_next = torque_max_reg;
      irq_enable_next = irq_enable_reg;
      item_wide_next = item_wide_reg;
      item_data_next = item_data_reg;
      sel_next = sel_reg;
      ev_clear = '0;
      bvalid_next = bvalid_reg && !s_axi_bready;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg && !s_axi_rready;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (wr_go && s_axi_awaddr[31:8] == 24'h00_0000) begin
         hit = 1'b1;
         case (wa)
            OFS_CTRL: ctrl_next = (ctrl_reg & ~wm) | (s_axi_wdata & wm);
            OFS_FREQ_MAX: freq_max_next = s_axi_wdata[15:0];
            OFS_TORQUE_MAX: torque_max_next = s_axi_wdata[15:0];
            OFS_IRQ_CLEAR: ev_clear = s_axi_wdata[NUM_EV-1:0];
            OFS_IRQ_ENABLE: irq_enable_next = s_axi_wdata[NUM_EV-1:0];
            OFS_ITEM_WIDE: item_wide_next = s_axi_wdata[NUM_ITEMS-1:0];
            OFS_STATE, OFS_IRQ_STATUS, OFS_SET_FREQ: hit = 1'b1;
            default: begin
               if (wa >= OFS_ITEM_BASE && wa < OFS_SEL_BASE &&
                   wa[1:0] == 2'b00 && wa < OFS_ITEM_BASE + 8'(NUM_ITEMS*4)) begin
                  item_data_next[(wa[4:2])*32 +: 32] = s_axi_wdata;
               end else if (wa >= OFS_SEL_BASE && wa[1:0] == 2'b00 &&
                            wa < OFS_SEL_BASE + 8'(NUM_SEL*4)) begin
                  sel_next[(wa[5:2])*16 +: 16] = s_axi_wdata[15:0];
               end else begin
                  hit = 1'b0;
               end
            end
         endcase
      end
      if (wr_go) begin
         bvalid_next = 1'b1;
         bresp_next = hit ? RESP_OKAY : RESP_DECERR;
      end
      if (rd_go) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = 32'h0000_0000;
         if (s_axi_araddr[31:8] != 24'h00_0000) begin
            rresp_next = RESP_DECERR;
         end else begin
            case (ra)
               OFS_CTRL: rdata_next = ctrl_reg;
               OFS_FREQ_MAX: rdata_next = {16'h0000, freq_max_reg};
               OFS_TORQUE_MAX: rdata_next = {16'h0000, torque_max_reg};
               OFS_STATE: rdata_next = {8'h00, reply2_reg, reply1_reg,
                                        5'h00, reverse_reg, op_mode_reg};
               OFS_IRQ_STATUS: rdata_next = 32'(irq_status_reg);
               OFS_IRQ_CLEAR: rdata_next = 32'h0000_0000;
               OFS_IRQ_ENABLE: rdata_next = 32'(irq_enable_reg);
               OFS_SET_FREQ: rdata_next = {16'h0000, set_freq_reg};
               OFS_ITEM_WIDE: rdata_next = 32'(item_wide_reg);
               default: begin
                  if (ra >= OFS_ITEM_BASE && ra[1:0] == 2'b00 &&
                      ra < OFS_ITEM_BASE + 8'(NUM_ITEMS*4)) begin
                     rdata_next = item_data_reg[(ra[4:2])*32 +: 32];
                  end else if (ra >= OFS_SEL_BASE && ra[1:0] == 2'b00 &&
                               ra < OFS_SEL_BASE + 8'(NUM_SEL*4)) begin
                     rdata_next = {16'h0000, sel_reg[(ra[5:2])*16 +: 16]};
                  end else begin
                     rresp_next = RESP_DECERR;
                  end
               end
            endcase
         end
      end
   end

   // ***********************************************************
   // command replies
   // ***********************************************************
   assign freq_go = freq_set_request_ram || freq_set_request_nv;

   always_comb begin
      logic neg;
      logic [15:0] mag;
      logic [7:0] frep;
      logic [7:0] trep;
      logic [33:0] res;
      logic [1:0] mode;
      logic ok_mode;
      res = '0;
      mode = op_mode_reg;
      neg = ctrl_reg[CTRL_SIGN_BIT] && freq_command[15];
      mag = neg ? 16'(-freq_command) : freq_command;
      ok_mode = (op_mode_reg == MODE_NET);
      frep = range_reply(mag, freq_max_reg, ok_mode);
      trep = range_reply(torque_command, torque_max_reg, ok_mode);
      reply1_next = reply1_reg;
      reply2_next = reply2_reg;
      read_data_word_next = read_data_word_reg;
      slot_reply_next = slot_reply_reg;
      slot_data_next = slot_data_reg;
      set_freq_next = set_freq_reg;
      reverse_next = reverse_reg;
      ev_set = '0;
      if (freq_go) begin
         ev_set[EV_FREQ_DONE] = 1'b1;
         if (ctrl_reg[CTRL_TORQUE_BIT]) begin
            reply1_next = {trep[3:0], frep[3:0]};
         end else begin
            reply1_next = frep;
         end
         if (reply1_next != RC_OK) begin
            ev_set[EV_FAULT] = 1'b1;
         end
         if (frep == RC_OK) begin
            set_freq_next = mag;
            reverse_next = neg;
         end
      end
      if (instr_exec_request) begin
         ev_set[EV_INSTR_DONE] = 1'b1;
         for (int k = 0; k < NUM_EXEC; k++) begin
            res = exec_instr(instr_code[k*8 +: 8], instr_data[k*16 +: 16],
                             mode, drive_stopped,
                             ctrl_reg[CTRL_MODE_SEL_LSB +: 4]);
            mode = res[33:32];
            if (res[31:16] != 16'h0000) begin
               ev_set[EV_FAULT] = 1'b1;
            end
            if (k == 0) begin
               reply2_next = res[23:16];
               read_data_word_next = res[15:0];
            end else begin
               slot_reply_next[(k-1)*16 +: 16] = res[31:16];
               slot_data_next[(k-1)*16 +: 16] = res[15:0];
            end
         end
      end
      op_mode_next = mode;
   end

   // ***********************************************************
   // interrupt and response word area
   // ***********************************************************
   always_comb begin
      // a new event wins over a clear in the same cycle
      irq_status_next = (irq_status_reg & ~ev_clear) | ev_set;
      resp_next = '0;
      for (int s = 0; s < NUM_SEL; s++) begin
         resp_next[(FIRST_USER_WORD+2*s)*16 +: 32] =
            user_values[s*32 +: 32];
      end
      resp_next[REPLY_WORD*16 +: 16] = {reply2_reg, reply1_reg};
      resp_next[READ_WORD*16 +: 16] = read_data_word_reg;
      if (ctrl_reg[CTRL_SLOT_LAYOUT_BIT]) begin
         for (int k = 0; k < NUM_SLOTS; k++) begin
            resp_next[(SLOT_WORD_BASE+2*k)*16 +: 16] =
               slot_reply_reg[k*16 +: 16];
            resp_next[(SLOT_WORD_BASE+2*k+1)*16 +: 16] =
               slot_data_reg[k*16 +: 16];
         end
      end
   end

   assign irq = |(irq_status_reg & irq_enable_reg);
   assign response_word_area = resp_reg;
   assign op_mode = op_mode_reg;
   assign set_freq = set_freq_reg;
   assign reverse_dir = reverse_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= CTRL_RESET;
         freq_max_reg <= FREQ_MAX_RESET;
         torque_max_reg <= TORQUE_MAX_RESET;
         irq_status_reg <= '0;
         irq_enable_reg <= '0;
         item_wide_reg <= '0;
         item_data_reg <= '0;
         sel_reg <= {NUM_SEL{SEL_NONE}};
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
         op_mode_reg <= MODE_RESET;
         reply1_reg <= RC_OK;
         reply2_reg <= RC_OK;
         read_data_word_reg <= 16'h0000;
         slot_reply_reg <= '0;
         slot_data_reg <= '0;
         set_freq_reg <= 16'h0000;
         reverse_reg <= 1'b0;
         resp_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         freq_max_reg <= freq_max_next;
         torque_max_reg <= torque_max_next;
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= irq_enable_next;
         item_wide_reg <= item_wide_next;
         item_data_reg <= item_data_next;
         sel_reg <= sel_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         op_mode_reg <= op_mode_next;
         reply1_reg <= reply1_next;
         reply2_reg <= reply2_next;
         read_data_word_reg <= read_data_word_next;
         slot_reply_reg <= slot_reply_next;
         slot_data_reg <= slot_data_next;
         set_freq_reg <= set_freq_next;
         reverse_reg <= reverse_next;
         resp_reg <= resp_next;
      end
   end
endmodule : crrl_reply

/* File: crrl_reply_monitor.sv */
// ***********************************************************
// reply and bus timing checks
// ***********************************************************
module crrl_reply_mon
   import crrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic freq_set_request_ram,
   input wire logic freq_set_request_nv,
   input wire logic instr_exec_request,
   input wire logic [crrl_pkg::NUM_EXEC*8-1:0] instr_code,
   input wire logic drive_stopped,
   input wire logic [crrl_pkg::NUM_WORDS*16-1:0] response_word_area,
   input wire logic [1:0] op_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence quiet;
      !freq_set_request_ram && !freq_set_request_nv && !instr_exec_request;
   endsequence
   sequence exec_code(logic [7:0] c);
      instr_exec_request && instr_code[7:0] == c;
   endsequence
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=>
      s_axi_rvalid) else $error("read not answered");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   a_unmapped_read: assert property (s_axi_arvalid && !s_axi_rvalid &&
      s_axi_araddr[31:8] != 24'h0 |=> s_axi_rresp == RESP_DECERR &&
      s_axi_rdata == 32'h0) else $error("bad read not refused");
   a_reply_hold: assert property (quiet ##1 quiet |=>
      $stable(response_word_area[47:32])) else $error("reply moved");
   a_mode_read: assert property (exec_code(CODE_MODE_READ) |-> ##2
      response_word_area[63:48] == {14'h0, $past(op_mode, 2)} &&
      response_word_area[47:40] == RC_OK) else $error("mode read wrong");
   a_mode_fault: assert property (
      exec_code(CODE_MODE_WRITE) && !drive_stopped |-> ##2
      response_word_area[47:40] == RC_MODE_FAULT)
      else $error("running write accepted");
   a_bad_code: assert property (instr_exec_request &&
      !instr_code[7] && instr_code[7:0] != CODE_MODE_READ |-> ##2
      response_word_area[47:40] == RC_BAD_CODE) else $error("code kept");
endmodule : crrl_reply_mon

/* File: crrl_net_master.sv */
// ***********************************************************
// network master issuing requests
// ***********************************************************
module crrl_net_master
   import crrl_pkg::*;
(
   input wire logic aclk,
   input wire logic [crrl_pkg::NUM_WORDS*16-1:0] response_word_area,
   output logic freq_set_request_ram,
   output logic freq_set_request_nv,
   output logic instr_exec_request,
   output logic [15:0] freq_command,
   output logic [15:0] torque_command,
   output logic [crrl_pkg::NUM_EXEC*8-1:0] instr_code,
   output logic [crrl_pkg::NUM_EXEC*16-1:0] instr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {freq_set_request_ram, freq_set_request_nv} = 2'b00;
      {instr_exec_request, freq_command, torque_command} = 33'h0;
      instr_code = {NUM_EXEC{CODE_MODE_READ}};
      instr_data = '0;
   end
   task instr(input logic [7:0] c, input logic [15:0] d,
      input logic [7:0] c1, output logic [15:0] r);
      @(posedge aclk);
      instr_code[7:0] <= c;
      instr_code[15:8] <= c1;
      instr_data[15:0] <= d;
      instr_exec_request <= 1'b1;
      @(posedge aclk);
      instr_exec_request <= 1'b0;
      @(posedge aclk);
      #1 r = response_word_area[47:32];
   endtask : instr
   task freq(input logic [15:0] v, input logic [15:0] t,
      input logic nv, output logic [15:0] r);
      @(posedge aclk);
      freq_command <= v;
      torque_command <= t;
      freq_set_request_nv <= nv;
      freq_set_request_ram <= !nv;
      @(posedge aclk);
      {freq_set_request_nv, freq_set_request_ram} <= 2'b00;
      @(posedge aclk);
      #1 r = response_word_area[47:32];
   endtask : freq
endmodule : crrl_net_master

/* File: crrl_reply_tb.sv */
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module crrl_reply_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import crrl_pkg::*;
   logic aclk, aresetn, drive_stopped, reverse_dir, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, op_mode;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic freq_set_request_ram, freq_set_request_nv, instr_exec_request;
   logic [15:0] freq_command, torque_command, set_freq, r2;
   logic [NUM_EXEC*8-1:0] instr_code;
   logic [NUM_EXEC*16-1:0] instr_data;
   logic [NUM_WORDS*16-1:0] response_word_area;
   int bad_count = 0;
   int checks_done = 0;
   crrl_reply DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .freq_set_request_ram,
      .freq_set_request_nv, .instr_exec_request, .freq_command,
      .torque_command, .instr_code, .instr_data, .drive_stopped,
      .response_word_area, .op_mode, .set_freq, .reverse_dir, .irq);
   crrl_net_master net (.aclk, .response_word_area, .freq_set_request_ram,
      .freq_set_request_nv, .instr_exec_request, .freq_command,
      .torque_command, .instr_code, .instr_data);
   function logic [15:0] w(input int n);
      return response_word_area[16*n +: 16];
   endfunction : w
   task results;
      $display("mismatches %0d checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // every bus wait is bounded so a dead slave ends the run
   task tick(inout int n);
      n++;
      if (n > 100) begin
         bad_count++;
         results();
      end
   endtask : tick
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      n = 0;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      do begin @(posedge aclk); tick(n); end
      while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
      {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
      do begin @(posedge aclk); tick(n); end while (s_axi_bvalid !== 1'b1);
      `CHK(s_axi_bresp, e)
   endtask : wr
   // rready comes late on purpose so the slave must hold its answer
   task rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b0;
      do begin @(posedge aclk); tick(n); end while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do begin @(posedge aclk); tick(n); end while (s_axi_rvalid !== 1'b1);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, er)
   endtask : rd
   task ic(input logic [7:0] c, input logic [15:0] d, input logic [7:0] e);
      net.instr(c, d, CODE_MODE_READ, r2);
      `CHK(r2[15:8], e)
   endtask : ic
   task fc(input logic [15:0] v, input logic [15:0] t, input logic nv,
      input logic [7:0] e);
      net.freq(v, t, nv, r2);
      `CHK(r2[7:0], e)
   endtask : fc
   task iw(input int s, input logic [15:0] sel, input logic [31:0] wide,
      input logic [15:0] lo, input logic [15:0] hi);
      wr(OFS_ITEM_WIDE, wide, RESP_OKAY);
      wr(OFS_SEL_BASE + 8'(4 * s), {16'h0, sel}, RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(w(FIRST_USER_WORD + 2 * s), lo)
      `CHK(w(FIRST_USER_WORD + 2 * s + 1), hi)
   endtask : iw
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      {aresetn, drive_stopped, s_axi_awvalid, s_axi_wvalid} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_bready} = 3'b001;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK(op_mode, MODE_RESET)
      rd(OFS_FREQ_MAX, 32'h0000_ffff, RESP_OKAY);
      rd(8'hf0, 32'h0, RESP_DECERR);
      rd(32'h100, 32'h0, RESP_DECERR);
      wr(8'hf0, 32'h1, RESP_DECERR);
      ic(CODE_MODE_READ, 16'h0, RC_OK);
      `CHK(w(READ_WORD), {14'h0, MODE_EXT})
      ic(CODE_MODE_WRITE, 16'h0, RC_MODE_FAULT);
      @(posedge aclk) drive_stopped <= 1'b1;
      ic(8'h90, 16'h0, RC_MODE_FAULT);
      ic(CODE_MODE_WRITE, {14'h0, MODE_NET}, RC_OK);
      `CHK(op_mode, MODE_NET)
      ic(8'h90, 16'h0, RC_BAD_CODE);
      ic(8'h10, 16'h0, RC_BAD_CODE);
      ic(CODE_MODE_WRITE, 16'h0002, RC_RANGE);
      ic(CODE_MODE_WRITE, 16'h0005, RC_RANGE);
      wr(OFS_CTRL, 32'h0000_0060, RESP_OKAY);
      ic(CODE_MODE_WRITE, 16'h0002, RC_OK);
      ic(CODE_MODE_READ, 16'h0, RC_OK);
      `CHK(w(READ_WORD), 16'h0002)
      ic(CODE_MODE_WRITE, 16'h0000, RC_OK);
      wr(OFS_FREQ_MAX, 32'd100, RESP_OKAY);
      fc(16'd50, 16'h0, 1'b0, RC_OK);
      `CHK(set_freq, 16'd50)
      fc(16'd200, 16'h0, 1'b1, RC_RANGE);
      `CHK(set_freq, 16'd50)
      `CHK(r2[15:8], RC_OK)
      wr(OFS_CTRL, 32'h0000_0061, RESP_OKAY);
      fc(16'hfff6, 16'h0, 1'b1, RC_OK);
      `CHK(set_freq, 16'd10)
      `CHK(reverse_dir, 1'b1)
      wr(OFS_CTRL, 32'h0000_0063, RESP_OKAY);
      wr(OFS_TORQUE_MAX, 32'd100, RESP_OKAY);
      ic(CODE_MODE_WRITE, {14'h0, MODE_EXT}, RC_OK);
      `CHK(r2[7:0], RC_OK)
      fc(16'd50, 16'd200, 1'b0, 8'h31);
      wr(OFS_CTRL, 32'h0000_0067, RESP_OKAY);
      net.instr(CODE_MODE_WRITE, {14'h0, MODE_PANEL}, 8'h10, r2);
      `CHK(r2, 16'h0031)
      `CHK(w(SLOT_WORD_BASE), {8'h0, RC_BAD_CODE})
      `CHK(w(SLOT_WORD_BASE + 3), {14'h0, MODE_PANEL})
      wr(OFS_ITEM_BASE, 32'h1234_5678, RESP_OKAY);
      iw(13, ITEM_INDEX_BASE, 32'h1, 16'h5678, 16'h1234);
      iw(0, ITEM_INDEX_BASE, 32'h0, 16'h5678, 16'h0);
      iw(0, SEL_NONE, 32'h1, 16'h0, 16'h0);
      iw(0, 16'h0050, 32'h1, 16'h0, 16'h0);
      wr(OFS_IRQ_ENABLE, 32'h1, RESP_OKAY);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_CLEAR, 32'h7, RESP_OKAY);
      `CHK(irq, 1'b0)
      fc(16'd5, 16'h0, 1'b0, 8'h11);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
      `CHK(irq, 1'b0)
      rd(OFS_IRQ_STATUS, 32'h5, RESP_OKAY);
      results();
   end
endmodule : crrl_reply_tb
bind crrl_reply crrl_reply_mon mon (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_wvalid, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .freq_set_request_ram, .freq_set_request_nv, .instr_exec_request,
   .instr_code, .drive_stopped, .response_word_area, .op_mode);
